// *** common/mgd_map.svh ***
// Register offsets, field positions, defaults and timing for the register bank
`ifndef MGD_MAP_SVH
`define MGD_MAP_SVH
`define MGD_ADDR_WARN 4'h1
`define MGD_ADDR_DSF 4'h2
`define MGD_ADDR_CHIP 4'h3
`define MGD_ADDR_GSF 4'h4
`define MGD_ADDR_HS 4'h5
`define MGD_ADDR_LS 4'h6
`define MGD_ADDR_TIMING 4'h7
`define MGD_ADDR_RSVD 4'h8
`define MGD_ADDR_OPER 4'h9
`define MGD_ADDR_AMP 4'hA
`define MGD_ADDR_REG 4'hB
`define MGD_ADDR_DSSENSE 4'hC
`define MGD_FRAME_BITS 5'h10
`define MGD_RW_POS 15
`define MGD_WARN_CLASS_POS 10
`define MGD_WARN_DSOR_POS 5
`define MGD_OPER_CLR_POS 1
`define MGD_OPER_SLEEP_POS 2
`define MGD_MASK_HS 11'h3FF
`define MGD_MASK_TIMING 11'h3FF
`define MGD_MASK_OPER 11'h7FF
`define MGD_MASK_AMP 11'h7FF
`define MGD_MASK_REG 11'h31F
`define MGD_MASK_DSSENSE 11'h0FF
`define MGD_MASK_WARN 11'h5DF
`define MGD_MASK_DSF 11'h7E7
`define MGD_MASK_CHIP 11'h777
`define MGD_MASK_GSF 11'h7E0
`define MGD_DEF_HS 11'h0344
`define MGD_DEF_LS 11'h0344
`define MGD_DEF_TIMING 11'h0216
`define MGD_DEF_OPER 11'h0020
`define MGD_DEF_AMP 11'h0000
`define MGD_DEF_REG 11'h010A
`define MGD_DEF_DSSENSE 11'h00C8
`define MGD_GAP_NS 500
`define MGD_CLK_NS 10
`define MGD_GAP_CYC ((`MGD_GAP_NS + `MGD_CLK_NS - 1) / `MGD_CLK_NS)
`endif

// *** common/mgd_pkg.sv ***
// Types shared by the register bank
package mgd_pkg;
   typedef enum logic [1:0] {
      MGD_IDLE,
      MGD_SHIFT,
      MGD_DONE
   } mgd_state_t;
endpackage

// *** rtl/mgd_reg_bank.sv ***
// Serial register bank of a three-phase gate driver
//
// Operation
// - top frame bit 0 writes, 1 reads
// - on read, shift addressed register out D10 first in same frame
// - writes to status registers change nothing, except that a warning register write clears it as a read does
// - status register access services the watchdog
// - control registers readable, not cleared by read or gate-enable
// - control registers take defaults at power-up
// - control registers take defaults on entering sleep
// - warning bit 10 shows warning (0) or latched fault (1)
// - warning bit 5 is live OR of drain-source fault bits
// - warning register carries temperature, supply and pump flags
// - register 2 holds drain-source faults and sense overcurrent
// - register 3 holds chip fault bits
// - register 4 holds gate-source faults, low bits reserved
// - registers 5 and 6 hold drive time and current codes
// - register 7 holds freewheel, mode, dead, blank, deglitch
// - register 9 upper bits hold protection and watchdog options
// - register 9 lower bits hold watchdog, sleep, clear, threshold
// - register A holds amplifier calibration, blanking, gains
// - register B holds reference, sleep delay, regulator fields
// - register C holds trip level and protect mode
// - frames are 16 bits; other lengths modify nothing
// - write frame returns previous register contents
// - writing clear-latched-faults clears latched faults
// - warning bit clears on read only once condition is gone
`timescale 1ns/1ps
`include "mgd_map.svh"
module mgd_reg_bank #(
   parameter int DATA_W = 11
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic sclk,
   input wire logic scs_n,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe,
   input wire logic sleep_entry,
   input wire logic [DATA_W-1:0] warn_cond,
   input wire logic latched_fault,
   input wire logic [DATA_W-1:0] dsf_cond,
   input wire logic [DATA_W-1:0] chip_cond,
   input wire logic [DATA_W-1:0] gsf_cond,
   output logic clear_faults,
   output logic watchdog_kick,
   output logic sleep_request,
   output logic [DATA_W-1:0] high_side_drive_ctrl,
   output logic [DATA_W-1:0] low_side_drive_ctrl,
   output logic [DATA_W-1:0] drive_timing_ctrl,
   output logic [DATA_W-1:0] chip_operation_ctrl,
   output logic [DATA_W-1:0] amplifier_ctrl,
   output logic [DATA_W-1:0] regulator_ctrl,
   output logic [DATA_W-1:0] drain_source_sense_ctrl
);
   initial begin
      if (DATA_W != 11) begin
         $error("mgd_reg_bank supports DATA_W of 11 only");
      end
   end

   mgd_pkg::mgd_state_t state_q;
   logic sclk_q;
   logic [15:0] shin_q;
   logic [DATA_W-1:0] shout_q;
   logic [4:0] count_q;
   logic [3:0] addr_q;
   logic [DATA_W-1:0] hs_q, ls_q, tim_q, oper_q, amp_q, reg_q, dss_q;
   logic [DATA_W-1:0] warn_q, dsf_q, chip_q, gsf_q;
   logic [DATA_W-1:0] warn_view;
   logic [DATA_W-1:0] sel_data;
   logic rise, fall, frame_end, frame_ok, wr_ok, rd_warn;
   logic [3:0] frame_addr;

   assign rise = sclk && !sclk_q;
   assign fall = !sclk && sclk_q;
   assign frame_end = (state_q == mgd_pkg::MGD_SHIFT) && scs_n;
   assign frame_ok = frame_end && (count_q == `MGD_FRAME_BITS);
   assign frame_addr = shin_q[14:11];
   assign wr_ok = frame_ok && !shin_q[`MGD_RW_POS];
   assign rd_warn = frame_ok && (frame_addr == `MGD_ADDR_WARN);

   // live OR of six drain-source bits
   always_comb begin
      warn_view = warn_q & `MGD_MASK_WARN;
      warn_view[`MGD_WARN_CLASS_POS] = latched_fault;
      warn_view[`MGD_WARN_DSOR_POS] = |dsf_cond[10:5];
   end

   always_comb begin
      unique case (addr_q)
         `MGD_ADDR_WARN: sel_data = warn_view;
         `MGD_ADDR_DSF: sel_data = dsf_q & `MGD_MASK_DSF;
         `MGD_ADDR_CHIP: sel_data = chip_q & `MGD_MASK_CHIP;
         `MGD_ADDR_GSF: sel_data = gsf_q & `MGD_MASK_GSF;
         `MGD_ADDR_HS: sel_data = hs_q;
         `MGD_ADDR_LS: sel_data = ls_q;
         `MGD_ADDR_TIMING: sel_data = tim_q;
         `MGD_ADDR_OPER: sel_data = oper_q;
         `MGD_ADDR_AMP: sel_data = amp_q;
         `MGD_ADDR_REG: sel_data = reg_q;
         `MGD_ADDR_DSSENSE: sel_data = dss_q;
         default: sel_data = '0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= sclk;
      end
   end

   // Frame sequencing
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_q <= mgd_pkg::MGD_IDLE;
         count_q <= 5'h0;
         shin_q <= 16'h0000;
      end else begin
         unique case (state_q)
            mgd_pkg::MGD_IDLE: begin
               if (!scs_n) begin
                  state_q <= mgd_pkg::MGD_SHIFT;
                  count_q <= 5'h0;
               end
            end
            mgd_pkg::MGD_SHIFT: begin
               if (scs_n) begin
                  state_q <= mgd_pkg::MGD_DONE;
               end else if (fall) begin
                  shin_q <= {shin_q[14:0], sdi};
                  if (count_q != 5'h1F) begin
                     count_q <= count_q + 5'h1;
                  end
               end
            end
            mgd_pkg::MGD_DONE: state_q <= mgd_pkg::MGD_IDLE;
         endcase
      end
   end

   // Address captured after five bits; response loaded then
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         addr_q <= 4'h0;
         shout_q <= '0;
      end else if (state_q == mgd_pkg::MGD_SHIFT && !scs_n) begin
         if (fall && count_q == 5'h4) begin
            addr_q <= {shin_q[2:0], sdi};
         end else if (count_q == 5'h5 && rise) begin
            shout_q <= sel_data;
         end else if (rise && count_q > 5'h5) begin
            shout_q <= {shout_q[DATA_W-2:0], 1'b0};
         end
      end
   end

   always_comb begin
      sdo_oe = !scs_n;
      if (state_q == mgd_pkg::MGD_SHIFT && count_q == 5'h5 && sclk) begin
         sdo = sel_data[DATA_W-1];
      end else if (state_q == mgd_pkg::MGD_SHIFT && count_q > 5'h5) begin
         sdo = shout_q[DATA_W-1];
      end else begin
         sdo = 1'b0;
      end
   end

   // no clear on read or gate-enable
   always_ff @(posedge sys_clk) begin
      if (reset || sleep_entry) begin
         hs_q <= `MGD_DEF_HS;
         ls_q <= `MGD_DEF_LS;
         tim_q <= `MGD_DEF_TIMING;
         oper_q <= `MGD_DEF_OPER;
         amp_q <= `MGD_DEF_AMP;
         reg_q <= `MGD_DEF_REG;
         dss_q <= `MGD_DEF_DSSENSE;
      end else begin
         oper_q[`MGD_OPER_CLR_POS] <= 1'b0;
         if (wr_ok) begin
            unique case (frame_addr)
               `MGD_ADDR_HS: hs_q <= shin_q[10:0] & `MGD_MASK_HS;
               `MGD_ADDR_LS: ls_q <= shin_q[10:0] & `MGD_MASK_HS;
               `MGD_ADDR_TIMING: tim_q <= shin_q[10:0] & `MGD_MASK_TIMING;
               `MGD_ADDR_OPER: oper_q <= shin_q[10:0] & `MGD_MASK_OPER;
               `MGD_ADDR_AMP: amp_q <= shin_q[10:0] & `MGD_MASK_AMP;
               `MGD_ADDR_REG: reg_q <= shin_q[10:0] & `MGD_MASK_REG;
               `MGD_ADDR_DSSENSE: dss_q <= shin_q[10:0] & `MGD_MASK_DSSENSE;
               default: ;
            endcase
         end
      end
   end

   // read clears only if condition gone; set wins
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         warn_q <= '0;
      end else if (rd_warn) begin
         warn_q <= warn_cond;
      end else begin
         warn_q <= warn_q | warn_cond;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset || clear_faults) begin
         dsf_q <= '0;
         chip_q <= '0;
         gsf_q <= '0;
      end else begin
         dsf_q <= dsf_q | dsf_cond;
         chip_q <= chip_q | chip_cond;
         gsf_q <= gsf_q | gsf_cond;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         watchdog_kick <= 1'b0;
      end else begin
         watchdog_kick <= frame_ok && frame_addr >= `MGD_ADDR_WARN
            && frame_addr <= `MGD_ADDR_GSF;
      end
   end

   assign clear_faults = oper_q[`MGD_OPER_CLR_POS];
   assign sleep_request = oper_q[`MGD_OPER_SLEEP_POS];
   assign high_side_drive_ctrl = hs_q;
   assign low_side_drive_ctrl = ls_q;
   assign drive_timing_ctrl = tim_q;
   assign chip_operation_ctrl = oper_q;
   assign amplifier_ctrl = amp_q;
   assign regulator_ctrl = reg_q;
   assign drain_source_sense_ctrl = dss_q;
endmodule

// *** tb/mgd_reg_bank_properties.sv ***
// Port checker for the gate driver register bank
`timescale 1ns/1ps
`include "mgd_map.svh"
module mgd_reg_bank_props (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic scs_n,
   input wire logic sdo_oe,
   input wire logic sleep_entry,
   input wire logic sleep_request,
   input wire logic watchdog_kick,
   input wire logic clear_faults,
   input wire logic [10:0] high_side_drive_ctrl,
   input wire logic [10:0] chip_operation_ctrl,
   input wire logic [10:0] regulator_ctrl
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   property p_oe; sdo_oe == !scs_n; endproperty
   a_oe: assert property (p_oe) else $error("sdo enable wrong");
   property p_def; $past(reset) |-> high_side_drive_ctrl == `MGD_DEF_HS
      && chip_operation_ctrl == `MGD_DEF_OPER; endproperty
   a_def: assert property (p_def) else $error("no default");
   property p_slp; sleep_entry |-> ##[1:2]
      (high_side_drive_ctrl == `MGD_DEF_HS); endproperty
   a_slp: assert property (p_slp) else $error("sleep kept");
   property p_req; sleep_request == chip_operation_ctrl[2]; endproperty
   a_req: assert property (p_req) else $error("sleep level");
   property p_rsv; regulator_ctrl[10] == 1'b0
      && regulator_ctrl[7:5] == 3'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved set");
   property p_hold; !scs_n && !sleep_entry |=>
      $stable(high_side_drive_ctrl) && $stable(regulator_ctrl); endproperty
   a_hold: assert property (p_hold) else $error("mid frame");
   property p_kick; watchdog_kick |-> scs_n ##1 !watchdog_kick; endproperty
   a_kick: assert property (p_kick) else $error("kick pulse");
   property p_clr; clear_faults |-> scs_n ##1 !clear_faults; endproperty
   a_clr: assert property (p_clr) else $error("clear pulse");
endmodule
bind mgd_reg_bank mgd_reg_bank_props mgd_reg_bank_props_inst (
   .sys_clk, .reset, .scs_n, .sdo_oe, .sleep_entry, .sleep_request,
   .watchdog_kick, .clear_faults, .high_side_drive_ctrl,
   .chip_operation_ctrl, .regulator_ctrl);

// *** tb/mgd_spi_host.sv ***
// Serial host model driving framed transfers
`timescale 1ns/1ps
module mgd_spi_host (
   input wire logic sys_clk,
   input wire logic sdo,
   output logic sclk,
   output logic scs_n,
   output logic sdi
);
   initial begin
      sclk = 1'b0;
      scs_n = 1'b1;
      sdi = 1'b0;
   end
   task automatic xfer(input logic [15:0] w, input int n,
      output logic [10:0] r);
      r = 11'h000;
      @(negedge sys_clk) scs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         repeat (4) @(negedge sys_clk);
         sclk = 1'b1;
         sdi = w[15-i];
         repeat (4) @(negedge sys_clk);
         r = {r[9:0], sdo};
         sclk = 1'b0;
      end
      repeat (4) @(negedge sys_clk);
      scs_n = 1'b1;
      sdi = ~sdi;
      repeat (60) @(negedge sys_clk);
   endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the gate driver register bank
`timescale 1ns/1ps
`include "mgd_map.svh"
module testbench;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic sleep_entry = 1'b0;
   logic latched_fault = 1'b0;
   logic [10:0] warn_cond = 11'h000;
   logic [10:0] dsf_cond = 11'h000;
   logic [10:0] chip_cond = 11'h000;
   logic [10:0] gsf_cond = 11'h000;
   logic sclk, scs_n, sdi, sdo, sdo_oe, clear_faults, watchdog_kick;
   logic sleep_request;
   logic [10:0] r;
   int bad_count = 0;
   int num_checks = 0;
   int kicks = 0;
   int cycles = 0;
   int k;
   logic [3:0] ad [7] = '{`MGD_ADDR_HS, `MGD_ADDR_LS, `MGD_ADDR_TIMING,
      `MGD_ADDR_OPER, `MGD_ADDR_AMP, `MGD_ADDR_REG, `MGD_ADDR_DSSENSE};
   logic [10:0] df [7] = '{`MGD_DEF_HS, `MGD_DEF_LS, `MGD_DEF_TIMING,
      `MGD_DEF_OPER, `MGD_DEF_AMP, `MGD_DEF_REG, `MGD_DEF_DSSENSE};
   // Clear command bit reads back low
   logic [10:0] mk [7] = '{`MGD_MASK_HS, `MGD_MASK_HS, `MGD_MASK_TIMING,
      11'h7FD, `MGD_MASK_AMP, `MGD_MASK_REG, `MGD_MASK_DSSENSE};
   mgd_reg_bank mgd_reg_bank_inst (.sys_clk, .reset, .sclk, .scs_n, .sdi,
      .sdo, .sdo_oe, .sleep_entry, .warn_cond, .latched_fault, .dsf_cond,
      .chip_cond, .gsf_cond, .clear_faults, .watchdog_kick, .sleep_request,
      .high_side_drive_ctrl(), .low_side_drive_ctrl(), .drive_timing_ctrl(),
      .chip_operation_ctrl(), .amplifier_ctrl(), .regulator_ctrl(),
      .drain_source_sense_ctrl());
   mgd_spi_host mgd_spi_host_inst (.sys_clk, .sdo, .sclk, .scs_n, .sdi);
   always #5 sys_clk = ~sys_clk;
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (watchdog_kick === 1'b1)
         kicks++;
      if (cycles == 20000) begin
         bad_count++;
         $display("[FAIL] %0t timeout", $time);
         test_done();
      end
   end
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [3:0] a, input logic [10:0] exp);
      mgd_spi_host_inst.xfer({1'b1, a, 11'h000}, 16, r);
      chk(r, exp);
   endtask
   task automatic wr(input logic [3:0] a, input logic [10:0] d,
      input logic [10:0] old);
      mgd_spi_host_inst.xfer({1'b0, a, d}, 16, r);
      chk(r, old);
   endtask
   initial begin
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk) reset = 1'b0;
      for (int i = 0; i < 7; i++) begin
         rd(ad[i], df[i]);
         wr(ad[i], 11'h7FF, df[i]);
         if (i == 3)
            chk({10'h000, sleep_request}, 11'h001);
         rd(ad[i], mk[i]);
         rd(ad[i], mk[i]);
         wr(ad[i], df[i], mk[i]);
      end
      mgd_spi_host_inst.xfer({1'b0, `MGD_ADDR_HS, 11'h155}, 15, r);
      rd(`MGD_ADDR_HS, `MGD_DEF_HS);
      wr(`MGD_ADDR_HS, 11'h0AA, `MGD_DEF_HS);
      @(negedge sys_clk) sleep_entry = 1'b1;
      @(negedge sys_clk) sleep_entry = 1'b0;
      rd(`MGD_ADDR_HS, `MGD_DEF_HS);
      wr(`MGD_ADDR_RSVD, 11'h7FF, 11'h000);
      rd(`MGD_ADDR_RSVD, 11'h000);
      {warn_cond, dsf_cond, chip_cond, gsf_cond} = {44{1'b1}};
      repeat (2) @(negedge sys_clk);
      {warn_cond, dsf_cond, chip_cond, gsf_cond} = 44'h0;
      warn_cond = 11'h001;
      rd(`MGD_ADDR_DSF, `MGD_MASK_DSF);
      rd(`MGD_ADDR_CHIP, `MGD_MASK_CHIP);
      rd(`MGD_ADDR_GSF, `MGD_MASK_GSF);
      wr(`MGD_ADDR_DSF, 11'h000, `MGD_MASK_DSF);
      rd(`MGD_ADDR_DSF, `MGD_MASK_DSF);
      k = kicks;
      rd(`MGD_ADDR_WARN, 11'h1DF);
      chk(11'(kicks - k), 11'h001);
      dsf_cond = 11'h400;
      rd(`MGD_ADDR_WARN, 11'h021);
      dsf_cond = 11'h000;
      warn_cond = 11'h000;
      wr(`MGD_ADDR_OPER, `MGD_DEF_OPER | 11'h002, `MGD_DEF_OPER);
      rd(`MGD_ADDR_DSF, 11'h000);
      rd(`MGD_ADDR_WARN, 11'h001);
      latched_fault = 1'b1;
      rd(`MGD_ADDR_WARN, 11'h400);
      test_done();
   end
endmodule
